/* hw/frame_pkg.sv */
// shared constants and carrier types for the serial slave frame handler
package frame_pkg;

  // ----------------------------------------
  // function codes
  // ----------------------------------------
  localparam logic [7:0] FN_READ_HOLD = 8'h03;
  localparam logic [7:0] FN_READ_INPUT = 8'h04;
  localparam logic [7:0] FN_WRITE_ONE = 8'h06;
  localparam logic [7:0] FN_SPECIAL_OP = 8'h09;
  localparam logic [7:0] FN_WRITE_MANY = 8'h10;
  localparam logic [7:0] SUBFN_REMOTE_RUN = 8'h30;
  localparam logic [7:0] CTRL_START = 8'h1A;
  localparam logic [7:0] CTRL_STOP = 8'h1B;
  localparam logic [7:0] EXC_FLAG = 8'h80;

  // ----------------------------------------
  // exception codes
  // ----------------------------------------
  localparam logic [7:0] EXC_ILLEGAL_FN = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
  localparam logic [7:0] EXC_ILLEGAL_DATA = 8'h03;
  localparam logic [7:0] EXC_BUSY = 8'h06;
  localparam logic [7:0] EXC_NAK = 8'h07;
  localparam logic [7:0] EXC_BAD_LENGTH = 8'h10;

  // ----------------------------------------
  // limits, crc and reset values
  // ----------------------------------------
  localparam int MAX_REGS = 125;
  localparam int BYTES_PER_REG = 2;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [15:0] OFF_VALUE = 16'hFFFF;
  localparam logic [7:0] SLAVE_ADDR_RST = 8'hF7;
  localparam int FIFO_DEPTH = 8;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] data;
    logic last;
  } byte_s;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] data;
  } reg_wr_s;

endpackage

/* hw/byte_fifo.sv */
// synchronous valid/ready fifo used in the response byte path
`timescale 1ns/100ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("byte_fifo depth must be a power of two, at least 2");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  logic push;
  logic pop;

  // full when pointers differ only in the wrap bit
  assign in_ready = (wr_ptr_r[AW] == rd_ptr_r[AW]) || (wr_ptr_r[AW-1:0] != rd_ptr_r[AW-1:0]);
  assign out_valid = wr_ptr_r != rd_ptr_r;
  assign out_data = mem[rd_ptr_r[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* hw/serial_slave_frame_handler.sv */
// slave-side frame decoder and response builder for the serial register link
// Operation
// - control byte 1A starts, 1B stops
// - write-multiple limited to 125 registers
// - byte count is twice register count
// - write-multiple reply echoes address, function, start, count
// - normal reply echoes received function code
// - exception reply sets function bit 80
// - exception reply is address, function, code, crc
// - unsupported function gives exception 01
// - invalid register address gives exception 02
// - invalid data gives exception 03
// - busy gives exception 06
// - unperformable function gives exception 07
// - register count above 125 gives 16
// - crc low byte first on serial link
// - front port sends crc high byte first
// - ffff encodes the OFF setpoint value
// - remote start/stop is function 9, sub 48
// - read reply byte count matches data bytes
// - function 4 handled as function 3
// - write-single reply mirrors the query
`timescale 1ns/100ps
`default_nettype none
module serial_slave_frame_handler #(
  parameter int MAX_FRAME = 256,
  parameter logic [15:0] REG_BASE = 16'h03E9,
  parameter int REG_COUNT = 64
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic [7:0] SLAVE_ADDR,
  input wire logic FRONT_PORT,
  input wire logic RX_VALID,
  input wire logic [7:0] RX_DATA,
  input wire logic RX_END,
  input wire logic BUSY,
  input wire logic TX_READY,
  output logic TX_VALID,
  output logic [7:0] TX_DATA,
  output logic TX_LAST,
  output logic REG_WR_VALID,
  output logic [15:0] REG_WR_ADDR,
  output logic [15:0] REG_WR_DATA,
  output logic START_PULSE,
  output logic STOP_PULSE,
  input wire logic [15:0] READ_REG,
  output logic READ_REG_VALID
);
  initial begin
    if (MAX_FRAME < 8 || MAX_FRAME > 256 || REG_COUNT < 1) begin
      $error("serial_slave_frame_handler parameters out of range");
    end
  end
  typedef enum logic [2:0] {S_RX, S_CHECK, S_APPLY, S_HDR, S_BODY, S_CRC1, S_CRC2} state_e;
  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_m_r;
  logic rst_n_r;
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rst_m_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_n_r <= rst_m_r;
    end
  end
  // ----------------------------------------
  // crc-16 step, reflected polynomial
  // ----------------------------------------
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] x;
    x = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      x = x[0] ? ((x >> 1) ^ frame_pkg::CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction
  // ----------------------------------------
  // receive buffer
  // ----------------------------------------
  logic [7:0] rx_mem [MAX_FRAME];
  logic [8:0] rx_len_r;
  logic rx_ovf_r;
  state_e state_r;
  always_ff @(posedge CLOCK) begin
    if (state_r == S_RX && RX_VALID && rx_len_r < 9'(MAX_FRAME)) begin
      rx_mem[rx_len_r[7:0]] <= RX_DATA;
    end
  end
  always_ff @(posedge CLOCK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rx_len_r <= '0;
      rx_ovf_r <= 1'b0;
    end else if (state_r == S_RX && RX_VALID) begin
      if (rx_len_r < 9'(MAX_FRAME)) begin
        rx_len_r <= rx_len_r + 9'd1;
      end else begin
        rx_ovf_r <= 1'b1;
      end
    end else if (state_r == S_CHECK) begin
      rx_len_r <= '0;
      rx_ovf_r <= 1'b0;
    end
  end
  // ----------------------------------------
  // frame check and classification
  // ----------------------------------------
  logic [7:0] fn;
  logic [15:0] start_addr;
  logic [15:0] reg_cnt;
  logic [15:0] crc_trailer;
  logic [15:0] crc_body;
  logic frame_ok;
  logic [7:0] exc_code;
  logic [8:0] reply_len;
  assign fn = rx_mem[1];
  assign start_addr = {rx_mem[2], rx_mem[3]};
  assign reg_cnt = {rx_mem[4], rx_mem[5]};
  // front port carries the trailer high byte first, so compare against the swapped order
  assign crc_trailer = FRONT_PORT ? {rx_mem[rx_len_r[7:0] - 8'd2], rx_mem[rx_len_r[7:0] - 8'd1]}
                                  : {rx_mem[rx_len_r[7:0] - 8'd1], rx_mem[rx_len_r[7:0] - 8'd2]};
  // recompute over body only; cheap since the frame is already stored
  always_comb begin
    crc_body = frame_pkg::CRC_INIT;
    for (int i = 0; i < MAX_FRAME - 2; i++) begin
      if (9'(i) + 9'd2 < rx_len_r) begin
        crc_body = crc_step(crc_body, rx_mem[i]);
      end
    end
  end
  assign frame_ok = !rx_ovf_r && rx_len_r >= 9'd4 && rx_mem[0] == SLAVE_ADDR
                    && crc_body == crc_trailer;
  logic addr_bad;
  logic one_bad;
  assign addr_bad = start_addr < REG_BASE
                    || ({16'h0, start_addr} + {16'h0, reg_cnt}) > ({16'h0, REG_BASE} + 32'(REG_COUNT));
  assign one_bad = start_addr < REG_BASE
                   || {16'h0, start_addr} >= ({16'h0, REG_BASE} + 32'(REG_COUNT));

  always_comb begin
    exc_code = 8'h00;
    reply_len = 9'd0;
    if (BUSY) begin
      exc_code = frame_pkg::EXC_BUSY;
    end else if (fn == frame_pkg::FN_READ_HOLD || fn == frame_pkg::FN_READ_INPUT) begin
      if (rx_len_r != 9'd8) begin
        exc_code = frame_pkg::EXC_ILLEGAL_DATA;
      end else if (reg_cnt > 16'(frame_pkg::MAX_REGS)) begin
        exc_code = frame_pkg::EXC_BAD_LENGTH;
      end else if (reg_cnt == 16'h0000 || addr_bad) begin
        exc_code = frame_pkg::EXC_ILLEGAL_ADDR;
      end else begin
        reply_len = 9'd3 + 9'(reg_cnt[7:0]) * 9'd2;
      end
    end else if (fn == frame_pkg::FN_WRITE_ONE) begin
      if (rx_len_r != 9'd8) begin
        exc_code = frame_pkg::EXC_ILLEGAL_DATA;
      end else if (one_bad) begin
        exc_code = frame_pkg::EXC_ILLEGAL_ADDR;
      end else begin
        reply_len = 9'd6;
      end
    end else if (fn == frame_pkg::FN_WRITE_MANY) begin
      if (reg_cnt > 16'(frame_pkg::MAX_REGS)) begin
        exc_code = frame_pkg::EXC_BAD_LENGTH;
      end else if ({8'h00, rx_mem[6]} != 16'(reg_cnt * 16'(frame_pkg::BYTES_PER_REG))
                   || rx_len_r != 9'd9 + 9'(rx_mem[6]) || reg_cnt == 16'h0000) begin
        exc_code = frame_pkg::EXC_ILLEGAL_DATA;
      end else if (addr_bad) begin
        exc_code = frame_pkg::EXC_ILLEGAL_ADDR;
      end else begin
        reply_len = 9'd6;
      end
    end else if (fn == frame_pkg::FN_SPECIAL_OP) begin
      if (rx_len_r != 9'd6 || rx_mem[2] != frame_pkg::SUBFN_REMOTE_RUN) begin
        exc_code = frame_pkg::EXC_NAK;
      end else if (rx_mem[3] != frame_pkg::CTRL_START && rx_mem[3] != frame_pkg::CTRL_STOP) begin
        exc_code = frame_pkg::EXC_ILLEGAL_DATA;
      end else begin
        reply_len = 9'd4;
      end
    end else begin
      exc_code = frame_pkg::EXC_ILLEGAL_FN;
    end
  end
  // ----------------------------------------
  // main sequencer
  // ----------------------------------------
  logic [7:0] exc_r;
  logic [8:0] len_r;
  logic [8:0] idx_r;
  logic [15:0] tx_crc_r;
  logic fifo_ready;
  logic push;
  frame_pkg::byte_s push_byte;
  logic [6:0] apply_cnt_r;
  assign push = (state_r == S_HDR || state_r == S_BODY || state_r == S_CRC1 || state_r == S_CRC2)
                && fifo_ready;
  always_ff @(posedge CLOCK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= S_RX;
      exc_r <= '0;
      len_r <= '0;
      idx_r <= '0;
      apply_cnt_r <= '0;
    end else begin
      case (state_r)
        S_RX: begin
          if (RX_END) begin
            state_r <= S_CHECK;
          end
        end
        S_CHECK: begin
          exc_r <= exc_code;
          len_r <= (exc_code != 8'h00) ? 9'd3 : reply_len;
          idx_r <= '0;
          apply_cnt_r <= '0;
          state_r <= !frame_ok ? S_RX : (exc_code != 8'h00) ? S_HDR : S_APPLY;
        end
        S_APPLY: begin
          // one register per cycle for write-multiple, single cycle otherwise
          if (fn != frame_pkg::FN_WRITE_MANY || apply_cnt_r + 7'd1 >= reg_cnt[6:0]) begin
            state_r <= S_HDR;
          end
          apply_cnt_r <= apply_cnt_r + 7'd1;
        end
        S_HDR, S_BODY: begin
          if (fifo_ready) begin
            idx_r <= idx_r + 9'd1;
            state_r <= (idx_r + 9'd1 >= len_r) ? S_CRC1 : S_BODY;
          end
        end
        S_CRC1: begin
          if (fifo_ready) begin
            state_r <= S_CRC2;
          end
        end
        S_CRC2: begin
          if (fifo_ready) begin
            state_r <= S_RX;
          end
        end
        default: begin
          state_r <= S_RX;
        end
      endcase
    end
  end
  // ----------------------------------------
  // register write and motor command outputs
  // ----------------------------------------
  logic [7:0] wr_ofs;
  assign wr_ofs = 8'(7 + 2 * int'(apply_cnt_r));
  always_ff @(posedge CLOCK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      REG_WR_VALID <= 1'b0;
      REG_WR_ADDR <= '0;
      REG_WR_DATA <= '0;
      START_PULSE <= 1'b0;
      STOP_PULSE <= 1'b0;
    end else begin
      REG_WR_VALID <= 1'b0;
      START_PULSE <= 1'b0;
      STOP_PULSE <= 1'b0;
      if (state_r == S_APPLY) begin
        if (fn == frame_pkg::FN_WRITE_ONE) begin
          REG_WR_VALID <= 1'b1;
          REG_WR_ADDR <= start_addr;
          REG_WR_DATA <= reg_cnt; // 16'hFFFF passes through as OFF
        end else if (fn == frame_pkg::FN_WRITE_MANY) begin
          REG_WR_VALID <= 1'b1;
          REG_WR_ADDR <= start_addr + {9'h000, apply_cnt_r};
          REG_WR_DATA <= {rx_mem[wr_ofs], rx_mem[wr_ofs + 8'd1]};
        end else if (fn == frame_pkg::FN_SPECIAL_OP) begin
          START_PULSE <= rx_mem[3] == frame_pkg::CTRL_START;
          STOP_PULSE <= rx_mem[3] == frame_pkg::CTRL_STOP;
        end
      end
    end
  end
  // ----------------------------------------
  // reply byte selection and crc
  // ----------------------------------------
  logic [7:0] body_byte;
  always_comb begin
    body_byte = rx_mem[idx_r[7:0]];
    if (idx_r == 9'd1) begin
      body_byte = (exc_r != 8'h00) ? (fn | frame_pkg::EXC_FLAG) : fn;
    end else if (exc_r != 8'h00 && idx_r == 9'd2) begin
      body_byte = exc_r;
    end else if ((fn == frame_pkg::FN_READ_HOLD || fn == frame_pkg::FN_READ_INPUT)
                 && idx_r == 9'd2) begin
      body_byte = 8'(reg_cnt[7:0] * 8'd2);
    end else if ((fn == frame_pkg::FN_READ_HOLD || fn == frame_pkg::FN_READ_INPUT)
                 && idx_r >= 9'd3) begin
      // register contents are supplied outside; high byte first
      body_byte = idx_r[0] ? READ_REG[15:8] : READ_REG[7:0];
    end
  end
  always_comb begin
    push_byte.last = state_r == S_CRC2;
    if (state_r == S_CRC1) begin
      push_byte.data = FRONT_PORT ? tx_crc_r[15:8] : tx_crc_r[7:0];
    end else if (state_r == S_CRC2) begin
      push_byte.data = FRONT_PORT ? tx_crc_r[7:0] : tx_crc_r[15:8];
    end else begin
      push_byte.data = body_byte;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      tx_crc_r <= frame_pkg::CRC_INIT;
    end else if (state_r == S_CHECK) begin
      tx_crc_r <= frame_pkg::CRC_INIT;
    end else if ((state_r == S_HDR || state_r == S_BODY) && fifo_ready) begin
      tx_crc_r <= crc_step(tx_crc_r, body_byte);
    end
  end

  // read strobe for the external register source, decoded from idx_r one cycle ahead
  always_ff @(posedge CLOCK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      READ_REG_VALID <= 1'b0;
    end else begin
      READ_REG_VALID <= (state_r == S_HDR || state_r == S_BODY)
                        && (fn == frame_pkg::FN_READ_HOLD || fn == frame_pkg::FN_READ_INPUT)
                        && exc_r == 8'h00 && idx_r >= 9'd2;
    end
  end
  // ----------------------------------------
  // output fifo and registered link outputs
  // ----------------------------------------
  frame_pkg::byte_s fifo_out;
  logic fifo_valid;
  logic fifo_pop;
  assign fifo_pop = fifo_valid && (!TX_VALID || TX_READY);

  byte_fifo #(.WIDTH($bits(frame_pkg::byte_s)), .DEPTH(frame_pkg::FIFO_DEPTH)) u_tx_fifo (
    .clk(CLOCK),
    .rst_n(rst_n_r),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(push_byte),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out)
  );

  always_ff @(posedge CLOCK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      TX_VALID <= 1'b0;
      TX_DATA <= '0;
      TX_LAST <= 1'b0;
    end else if (!TX_VALID || TX_READY) begin
      TX_VALID <= fifo_valid;
      TX_DATA <= fifo_out.data;
      TX_LAST <= fifo_out.last;
    end
  end
endmodule
`default_nettype wire

/* verification/frame_handler_monitor.sv */
// assertion checker bound to the frame handler top ports
`timescale 1ns/100ps
`default_nettype none
module frame_handler_monitor (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic [7:0] SLAVE_ADDR,
  input wire logic RX_END,
  input wire logic BUSY,
  input wire logic TX_READY,
  input wire logic TX_VALID,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_LAST,
  input wire logic REG_WR_VALID,
  input wire logic START_PULSE,
  input wire logic STOP_PULSE
);
  // ----------------------------------------
  // reply byte position tracking
  // ----------------------------------------
  logic [7:0] idx_r;
  logic [7:0] fn_r;
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      idx_r <= 8'h00;
      fn_r <= 8'h00;
    end else if (TX_VALID && TX_READY) begin
      idx_r <= TX_LAST ? 8'h00 : idx_r + 8'h01;
      if (idx_r == 8'h01)
        fn_r <= TX_DATA;
    end
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  tx_hold_a:
    assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA) && $stable(TX_LAST))
    else $error("reply byte changed before it was taken");
  addr_echo_a:
    assert property (TX_VALID && TX_READY && idx_r == 8'h00 |-> TX_DATA == SLAVE_ADDR)
    else $error("reply does not start with own address");
  exc_len_a:
    assert property (TX_VALID && TX_READY && TX_LAST && fn_r[7] |-> idx_r == 8'h04)
    else $error("exception reply length wrong");
  exc_code_a:
    assert property (TX_VALID && TX_READY && idx_r == 8'h02 && fn_r[7]
      |-> TX_DATA inside {8'h01, 8'h02, 8'h03, 8'h06, 8'h07, 8'h10})
    else $error("unknown exception code");
  early_last_a:
    assert property (TX_VALID && TX_READY && idx_r < 8'h04 |-> !TX_LAST)
    else $error("reply ended too early");
  wr_quiet_a:
    assert property (REG_WR_VALID |-> !TX_VALID)
    else $error("reply started before writes done");
  busy_nowrite_a:
    assert property ((RX_END && BUSY) ##1 BUSY
      |=> (!REG_WR_VALID && !START_PULSE && !STOP_PULSE) [*3])
    else $error("busy frame caused an action");
  run_pulse_a:
    assert property (START_PULSE || STOP_PULSE
      |-> !(START_PULSE && STOP_PULSE) ##1 (!START_PULSE && !STOP_PULSE))
    else $error("run pulse malformed");
endmodule
bind serial_slave_frame_handler frame_handler_monitor mon (.CLOCK(CLOCK), .RST_N(RST_N),
  .SLAVE_ADDR(SLAVE_ADDR), .RX_END(RX_END), .BUSY(BUSY), .TX_READY(TX_READY),
  .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_LAST(TX_LAST),
  .REG_WR_VALID(REG_WR_VALID), .START_PULSE(START_PULSE), .STOP_PULSE(STOP_PULSE));
`default_nettype wire

/* verification/modbus_host.sv */
// behavioural link master: sends queries, collects reply bytes
`timescale 1ns/100ps
`default_nettype none
module modbus_host (
  input wire logic clk,
  input wire logic front,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_end,
  output logic tx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last
);
  // ----------------------------------------
  // framing and reply capture
  // ----------------------------------------
  logic [8:0] got_q[$];
  int stall;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'hA5;
    rx_end = 1'b0;
    tx_ready = 1'b1;
    stall = 0;
  end
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int b = 0; b < 8; b++)
        c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction
  // bad flips one crc bit so the frame must be dropped
  task automatic send(input logic [7:0] q[$], input logic bad);
    logic [15:0] c;
    c = crc16(q) ^ {15'h0000, bad};
    q.push_back(front ? c[15:8] : c[7:0]);
    q.push_back(front ? c[7:0] : c[15:8]);
    foreach (q[i]) begin
      @(negedge clk);
      rx_valid = 1'b1;
      rx_data = q[i];
    end
    @(negedge clk);
    rx_valid = 1'b0;
    rx_data = ~rx_data;
    rx_end = 1'b1;
    @(negedge clk);
    rx_end = 1'b0;
  endtask
  // a slow sink backs the reply queue up until it refuses
  always @(negedge clk) begin
    tx_ready <= (stall == 0);
    if (stall > 0)
      stall <= stall - 1;
  end
  always @(posedge clk) begin
    if (tx_valid && tx_ready)
      got_q.push_back({tx_last, tx_data});
  end
endmodule
`default_nettype wire

/* verification/tb_serial_slave_frame_handler.sv */
// self-checking bench for the serial slave frame handler
`timescale 1ns/100ps
`default_nettype none
module tb_serial_slave_frame_handler;
  logic clk, rst_n, front, busy, rxv, rxe, txr, txv, txl, wrv, st, sp, rrv;
  logic [7:0] rxd, txd;
  logic [15:0] wra, wrd, rreg;
  logic [7:0] q[$];
  logic [7:0] e[$];
  logic [31:0] wq[$];
  logic [31:0] seed;
  int failures, tests_run, st_n, sp_n, rr_n;
  serial_slave_frame_handler uut (.CLOCK(clk), .RST_N(rst_n), .SLAVE_ADDR(8'hF7),
    .FRONT_PORT(front), .RX_VALID(rxv), .RX_DATA(rxd), .RX_END(rxe), .BUSY(busy),
    .TX_READY(txr), .TX_VALID(txv), .TX_DATA(txd), .TX_LAST(txl), .REG_WR_VALID(wrv),
    .REG_WR_ADDR(wra), .REG_WR_DATA(wrd), .START_PULSE(st), .STOP_PULSE(sp),
    .READ_REG(rreg), .READ_REG_VALID(rrv));
  modbus_host host (.clk(clk), .front(front), .rx_valid(rxv), .rx_data(rxd), .rx_end(rxe),
    .tx_ready(txr), .tx_valid(txv), .tx_data(txd), .tx_last(txl));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  task automatic test_done();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (x !== g) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, x, g);
    end
  endtask
  // empty e means the frame must get no reply at all
  task automatic xact(input logic bad);
    logic [15:0] c;
    int n;
    host.got_q.delete();
    host.send(q, bad);
    host.stall = 12;
    if (e.size() > 0) begin
      c = host.crc16(e);
      e.push_back(front ? c[15:8] : c[7:0]);
      e.push_back(front ? c[7:0] : c[15:8]);
    end
    for (n = 0; n < 300 && host.got_q.size() < e.size(); n++)
      @(negedge clk);
    if (n == 300) begin
      failures++;
      test_done();
    end
    repeat (30) @(negedge clk);
    chk("reply length", e.size(), host.got_q.size());
    foreach (e[i])
      chk("reply byte", {i == e.size() - 1, e[i]}, host.got_q[i]);
  endtask
  task automatic exc(input logic [7:0] code);
    e = '{8'hF7, q[1] | 8'h80, code};
    xact(1'b0);
  endtask
  always @(negedge clk) begin
    if (st === 1'b1)
      st_n++;
    if (sp === 1'b1)
      sp_n++;
    if (rrv === 1'b1)
      rr_n++;
    if (wrv === 1'b1)
      chk("register write", wq.size() > 0 ? wq.pop_front() : 32'hXXXXXXXX, {wra, wrd});
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    front = 1'b0;
    busy = 1'b0;
    seed = 32'h0000002B;
    failures = 0;
    tests_run = 0;
    st_n = 0;
    sp_n = 0;
    rr_n = 0;
    rreg = 16'h0000;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    q = '{8'hF7, 8'h06, 8'h03, 8'hE9, 8'h00, 8'h32};
    e = q;
    wq.push_back(32'h03E90032);
    xact(1'b0);
    front = 1'b1;
    e = q;
    wq.push_back(32'h03E90032);
    xact(1'b0);
    front = 1'b0;
    q = '{8'hF7, 8'h06, 8'h03, 8'hEA, 8'hFF, 8'hFF};
    busy = 1'b1;
    exc(8'h06);
    busy = 1'b0;
    e = q;
    wq.push_back(32'h03EAFFFF);
    xact(1'b0);
    for (int k = 1; k < 4; k++) begin
      q = '{8'hF7, 8'h10, 8'h03, 8'hE9, 8'h00, k[7:0], 8'(2 * k)};
      e = q[0:5];
      for (int r = 0; r < k; r++) begin
        seed = xs(seed);
        q.push_back(seed[15:8]);
        q.push_back(seed[7:0]);
        wq.push_back({16'h03E9 + 16'(r), seed[15:0]});
      end
      xact(1'b0);
    end
    for (int k = 0; k < 2; k++) begin
      q = '{8'hF7, 8'h09, 8'h30, 8'h1A + 8'(k)};
      e = q;
      xact(1'b0);
    end
    chk("start pulses", 1, st_n);
    chk("stop pulses", 1, sp_n);
    q = '{8'hF7, 8'h09, 8'h30, 8'h55};
    exc(8'h03);
    q = '{8'hF7, 8'h09, 8'h31, 8'h1A};
    exc(8'h07);
    q = '{8'hF7, 8'h05, 8'h00, 8'h01, 8'h00, 8'h01};
    exc(8'h01);
    q = '{8'hF7, 8'h03, 8'h03, 8'hE8, 8'h00, 8'h01};
    exc(8'h02);
    q[1] = 8'h04;
    exc(8'h02);
    q = '{8'hF7, 8'h10, 8'h03, 8'hE9, 8'h00, 8'h7E, 8'h04, 8'h00, 8'h01, 8'h00, 8'h02};
    exc(8'h10);
    q[5] = 8'h02;
    q[6] = 8'h06;
    exc(8'h03);
    q[6] = 8'h04;
    e.delete();
    xact(1'b1);
    q[0] = 8'hF6;
    e.delete();
    xact(1'b0);
    chk("read status idle", 0, rr_n);
    for (int k = 0; k < 2; k++) begin
      seed = xs(seed);
      rreg = seed[15:0];
      q = '{8'hF7, 8'h03 + 8'(k), 8'h03, 8'hE9, 8'h00, 8'h02};
      e = '{8'hF7, q[1], 8'h04, rreg[15:8], rreg[7:0], rreg[15:8], rreg[7:0]};
      rr_n = 0;
      xact(1'b0);
      chk("read status", 1, rr_n >= 5);
    end
    chk("writes left", 0, wq.size());
    test_done();
  end
endmodule
`default_nettype wire
